// ===== dps_master_model.sv
// Master controller model issuing command word writes
`timescale 1ns/1ps
module dps_master_model (
   input  wire logic   sys_clk,
   output logic        cmd_wr,
   output logic [15:0] cmd_wr_data
);
   initial begin
      cmd_wr = 1'b0;
      cmd_wr_data = 16'h0000;
   end
   // One write after an idle stretch; data inverted once released
   task automatic put(input logic [15:0] d, input int slow);
      repeat (slow) @(posedge sys_clk);
      cmd_wr <= 1'b1;
      cmd_wr_data <= d;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
      cmd_wr_data <= ~d;
   endtask : put
endmodule : dps_master_model

// ===== dps_pkg.sv
// Constants, state codes and command word layout of the drive power state machine
package dps_pkg;

   // Object indices of the two words
   localparam logic [15:0] CMD_INDEX   = 16'h6040;
   localparam logic [15:0] STATE_INDEX = 16'h6041;

   // Word width and reset value of the command word
   localparam int          WORD_W    = 16;
   localparam logic [15:0] CMD_RESET = 16'h0000;

   // State word bit positions
   localparam int SW_ARMED    = 0;
   localparam int SW_ENERGY   = 1;
   localparam int SW_RUN      = 2;
   localparam int SW_ERROR    = 3;
   localparam int SW_VOLTAGE  = 4;
   localparam int SW_NO_DECEL = 5;
   localparam int SW_INHIBIT  = 6;
   localparam int SW_HOLD     = 8;

   // Command patterns on command bits 2..0
   localparam logic [2:0] CMD_ARM      = 3'h6;
   localparam logic [2:0] CMD_ENERGIZE = 3'h7;

   // Operating states, Gray coded along the usual path
   typedef enum logic [2:0] {
      ST_INIT_PENDING = 3'h0,
      ST_INHIBITED    = 3'h1,
      ST_ARMED        = 3'h3,
      ST_ENERGIZED    = 3'h2,
      ST_RUNNING      = 3'h6,
      ST_EMER_DECEL   = 3'h7,
      ST_ERR_REACT    = 3'h5,
      ST_ERR_LATCHED  = 3'h4
   } dps_state_t;

   // Command word field layout
   typedef struct packed {
      logic [5:0] reserved;
      logic       mode_hi;
      logic       hold;
      logic       err_clr;
      logic [2:0] mode_lo;
      logic       run;
      logic       emer_n;
      logic       power;
      logic       energize;
   } dps_cmd_t;

endpackage : dps_pkg

// ===== dps_power_state_machine.sv
// Operating state machine of the drive, driven by command word writes
// Notes on behaviour
// - State shown on bits 0-3,5,6; energized, running, emergency decel patterns fixed.
// - Init pending clears bits 6,3,2,1,0.
// - Power inhibited sets bit 6, clears bits 3 to 0.
// - Armed sets bits 5 and 0, clears bits 6,3,2,1.
// - Error reaction sets bits 3-0; error latched sets only bit 3; bit 6 clear.
// - Bits 4,5,6,9 go to mode logic; bits 10-15 have no effect.
// - Command bit 8 at one triggers a hold of current motion.
// - Pattern 110 arms (T2,T6,T8); pattern 111 energizes from armed (T3).
// - Bit 1 clear drops power; bit 2 clear with bit 1 set starts emergency decel from running, drops power from armed or energized.
// - With 111, bit 3 set runs (T4,T16); bit 3 clear pauses (T5).
// - Rising edge of bit 7 leaves error latched for power inhibited.
// - No arming from power inhibited (T2) without valid bus voltage; validity shown on bit 4.
`timescale 1ns/1ps

module dps_power_state_machine #(
   parameter int WORD_W = dps_pkg::WORD_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire logic              cmd_wr,
   input  wire logic [WORD_W-1:0] cmd_wr_data,
   input  wire logic              init_done,
   input  wire logic              dc_bus_ok,
   input  wire logic              fault_event,
   input  wire logic              fault_react_done,
   input  wire logic              decel_done,
   output logic [WORD_W-1:0]      drive_command_word,
   output logic [WORD_W-1:0]      drive_state_word,
   output dps_pkg::dps_state_t    op_state,
   output logic                   power_stage_on,
   output logic                   motion_enable,
   output logic                   decel_active,
   output logic                   hold_active,
   output logic [3:0]             mode_ctrl
);

   dps_pkg::dps_cmd_t   wr_cmd;
   dps_pkg::dps_cmd_t   cur_cmd;
   dps_pkg::dps_state_t next_op_state;
   logic                pwr_drop;
   logic                emer_req;
   logic                arm_req;
   logic                energize_req;
   logic                run_req;
   logic                pause_req;
   logic                clr_edge;
   logic [WORD_W-1:0]   next_state_word;

   assign wr_cmd  = dps_pkg::dps_cmd_t'(cmd_wr_data);
   assign cur_cmd = dps_pkg::dps_cmd_t'(drive_command_word);

   // Command decode, valid only in a write cycle
   always_comb begin
      pwr_drop     = cmd_wr && !wr_cmd.power;
      emer_req     = cmd_wr && wr_cmd.power && !wr_cmd.emer_n;
      arm_req      = cmd_wr && ({wr_cmd.emer_n, wr_cmd.power, wr_cmd.energize}
                                == dps_pkg::CMD_ARM);
      energize_req = cmd_wr && ({wr_cmd.emer_n, wr_cmd.power, wr_cmd.energize}
                                == dps_pkg::CMD_ENERGIZE);
      run_req      = energize_req && wr_cmd.run;
      pause_req    = energize_req && !wr_cmd.run;
   end

   // Error clear edge, new bit 7 against the stored one
   always_comb begin
      clr_edge = cmd_wr && wr_cmd.err_clr && !cur_cmd.err_clr;
   end

   // Next operating state
   always_comb begin
      next_op_state = op_state;
      case (op_state)
         dps_pkg::ST_INIT_PENDING: begin
            if (init_done) begin
               next_op_state = dps_pkg::ST_INHIBITED;
            end
         end
         dps_pkg::ST_INHIBITED: begin
            if (arm_req && dc_bus_ok) begin
               next_op_state = dps_pkg::ST_ARMED;
            end
         end
         dps_pkg::ST_ARMED: begin
            if (pwr_drop || emer_req) begin
               next_op_state = dps_pkg::ST_INHIBITED;
            end else if (energize_req) begin
               next_op_state = dps_pkg::ST_ENERGIZED;
            end
         end
         dps_pkg::ST_ENERGIZED: begin
            if (pwr_drop || emer_req) begin
               next_op_state = dps_pkg::ST_INHIBITED;
            end else if (arm_req) begin
               next_op_state = dps_pkg::ST_ARMED;
            end else if (run_req) begin
               next_op_state = dps_pkg::ST_RUNNING;
            end
         end
         dps_pkg::ST_RUNNING: begin
            if (pwr_drop) begin
               next_op_state = dps_pkg::ST_INHIBITED;
            end else if (emer_req) begin
               next_op_state = dps_pkg::ST_EMER_DECEL;
            end else if (arm_req) begin
               next_op_state = dps_pkg::ST_ARMED;
            end else if (pause_req) begin
               next_op_state = dps_pkg::ST_ENERGIZED;
            end
         end
         dps_pkg::ST_EMER_DECEL: begin
            if (pwr_drop) begin
               next_op_state = dps_pkg::ST_INHIBITED;
            end else if (run_req) begin
               next_op_state = dps_pkg::ST_RUNNING;
            end else if (decel_done) begin
               next_op_state = dps_pkg::ST_INHIBITED;
            end
         end
         dps_pkg::ST_ERR_REACT: begin
            if (fault_react_done) begin
               next_op_state = dps_pkg::ST_ERR_LATCHED;
            end
         end
         dps_pkg::ST_ERR_LATCHED: begin
            if (clr_edge) begin
               next_op_state = dps_pkg::ST_INHIBITED;
            end
         end
         default: begin
            next_op_state = dps_pkg::ST_INIT_PENDING;
         end
      endcase
      // Fault overrides any command except an error clear edge in error latched
      if (fault_event && (op_state != dps_pkg::ST_ERR_REACT)
                      && (op_state != dps_pkg::ST_ERR_LATCHED)) begin
         next_op_state = dps_pkg::ST_ERR_REACT;
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         op_state <= dps_pkg::ST_INIT_PENDING;
      end else begin
         op_state <= next_op_state;
      end
   end

   // Command word storage, whole word kept for readback
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         drive_command_word <= dps_pkg::CMD_RESET;
      end else if (cmd_wr) begin
         drive_command_word <= cmd_wr_data;
      end
   end

   // State word encode from the next state
   always_comb begin
      next_state_word = '0;
      next_state_word[dps_pkg::SW_VOLTAGE] = dc_bus_ok;
      next_state_word[dps_pkg::SW_HOLD]    = cmd_wr ? wr_cmd.hold : cur_cmd.hold;
      // Bits 0-3, 5 and 6 written out for every state
      case (next_op_state)
         // Waiting for initialisation, all state bits low
         dps_pkg::ST_INIT_PENDING: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b0;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b0;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b0;
            next_state_word[dps_pkg::SW_RUN]      = 1'b0;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b0;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b0;
         end
         // Power stage locked out
         dps_pkg::ST_INHIBITED: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b1;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b0;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b0;
            next_state_word[dps_pkg::SW_RUN]      = 1'b0;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b0;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b0;
         end
         // Ready for energizing
         dps_pkg::ST_ARMED: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b0;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b1;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b0;
            next_state_word[dps_pkg::SW_RUN]      = 1'b0;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b0;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b1;
         end
         // Power stage on, no motion
         dps_pkg::ST_ENERGIZED: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b0;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b1;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b0;
            next_state_word[dps_pkg::SW_RUN]      = 1'b0;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b1;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b1;
         end
         // Motion enabled
         dps_pkg::ST_RUNNING: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b0;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b1;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b0;
            next_state_word[dps_pkg::SW_RUN]      = 1'b1;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b1;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b1;
         end
         // Emergency ramp, bit 5 low
         dps_pkg::ST_EMER_DECEL: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b0;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b0;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b0;
            next_state_word[dps_pkg::SW_RUN]      = 1'b1;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b1;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b1;
         end
         // Error reaction in progress
         dps_pkg::ST_ERR_REACT: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b0;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b0;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b1;
            next_state_word[dps_pkg::SW_RUN]      = 1'b1;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b1;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b1;
         end
         // Error held until a clear edge
         dps_pkg::ST_ERR_LATCHED: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b0;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b0;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b1;
            next_state_word[dps_pkg::SW_RUN]      = 1'b0;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b0;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b0;
         end
         default: begin
            next_state_word[dps_pkg::SW_INHIBIT]  = 1'b0;
            next_state_word[dps_pkg::SW_NO_DECEL] = 1'b0;
            next_state_word[dps_pkg::SW_ERROR]    = 1'b0;
            next_state_word[dps_pkg::SW_RUN]      = 1'b0;
            next_state_word[dps_pkg::SW_ENERGY]   = 1'b0;
            next_state_word[dps_pkg::SW_ARMED]    = 1'b0;
         end
      endcase
   end

   // Registered state word
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         drive_state_word <= '0;
      end else begin
         drive_state_word <= next_state_word;
      end
   end

   // Power stage on while energized, running or stopping
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         power_stage_on <= 1'b0;
      end else begin
         power_stage_on <= (next_op_state == dps_pkg::ST_ENERGIZED)
                        || (next_op_state == dps_pkg::ST_RUNNING)
                        || (next_op_state == dps_pkg::ST_EMER_DECEL)
                        || (next_op_state == dps_pkg::ST_ERR_REACT);
      end
   end

   // Motion allowed only while running
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         motion_enable <= 1'b0;
      end else begin
         motion_enable <= (next_op_state == dps_pkg::ST_RUNNING);
      end
   end

   // Ramp down in emergency decel and error reaction
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         decel_active <= 1'b0;
      end else begin
         decel_active <= (next_op_state == dps_pkg::ST_EMER_DECEL)
                      || (next_op_state == dps_pkg::ST_ERR_REACT);
      end
   end

   // Hold level follows bit 8 of each write
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         hold_active <= 1'b0;
      end else if (cmd_wr) begin
         hold_active <= wr_cmd.hold;
      end
   end

   // Mode controls pass on; reserved bits drive nothing
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mode_ctrl <= '0;
      end else if (cmd_wr) begin
         mode_ctrl <= {wr_cmd.mode_hi, wr_cmd.mode_lo};
      end
   end

endmodule : dps_power_state_machine

// ===== dps_sva.sv
// Port assertions for the drive power state machine
`timescale 1ns/1ps
module dps_sva #(
   parameter int WORD_W = 16
) (
   input wire logic                sys_clk,
   input wire logic                rstn,
   input wire logic                cmd_wr,
   input wire logic [WORD_W-1:0]   cmd_wr_data,
   input wire logic                dc_bus_ok,
   input wire logic                fault_event,
   input wire logic [WORD_W-1:0]   drive_command_word,
   input wire logic [WORD_W-1:0]   drive_state_word,
   input wire dps_pkg::dps_state_t op_state,
   input wire logic                hold_active
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   arm_go_a: assert property (
      cmd_wr && !fault_event && dc_bus_ok && cmd_wr_data[2:0] == 3'h6
      && op_state == dps_pkg::ST_INHIBITED |=> op_state == dps_pkg::ST_ARMED)
      else $error("arm command not taken");
   arm_block_a: assert property (
      op_state == dps_pkg::ST_INHIBITED && !dc_bus_ok |=> op_state != dps_pkg::ST_ARMED)
      else $error("armed without bus voltage");
   volt_bit_a: assert property (
      $past(rstn) |-> drive_state_word[4] == $past(dc_bus_ok))
      else $error("voltage bit wrong");
   run_word_a: assert property (
      op_state == dps_pkg::ST_RUNNING |-> (drive_state_word & 16'h006f) == 16'h0027)
      else $error("running pattern wrong");
   emer_go_a: assert property (
      cmd_wr && !fault_event && cmd_wr_data[2:1] == 2'h1 && op_state == dps_pkg::ST_RUNNING
      |=> op_state == dps_pkg::ST_EMER_DECEL && (drive_state_word & 16'h006f) == 16'h0007)
      else $error("emergency decel not entered");
   power_drop_a: assert property (
      cmd_wr && !fault_event && !cmd_wr_data[1] && op_state inside {dps_pkg::ST_ARMED,
      dps_pkg::ST_ENERGIZED, dps_pkg::ST_RUNNING, dps_pkg::ST_EMER_DECEL}
      |=> op_state == dps_pkg::ST_INHIBITED && (drive_state_word & 16'h006f) == 16'h0040)
      else $error("power drop not taken");
   hold_bit_a: assert property (
      cmd_wr |=> hold_active == $past(cmd_wr_data[8]) && drive_state_word[8] == hold_active)
      else $error("hold bit wrong");
   err_clear_a: assert property (
      cmd_wr && cmd_wr_data[7] && !drive_command_word[7]
      && op_state == dps_pkg::ST_ERR_LATCHED |=> op_state == dps_pkg::ST_INHIBITED)
      else $error("error clear not taken");
   latch_keep_a: assert property (
      op_state == dps_pkg::ST_ERR_LATCHED && !(cmd_wr && cmd_wr_data[7] && !drive_command_word[7])
      |=> op_state == dps_pkg::ST_ERR_LATCHED && drive_state_word[3:0] == 4'h8)
      else $error("error latched left wrongly");
endmodule : dps_sva

bind dps_power_state_machine dps_sva #(.WORD_W(WORD_W)) u_sva (.sys_clk, .rstn, .cmd_wr,
   .cmd_wr_data, .dc_bus_ok, .fault_event, .drive_command_word, .drive_state_word,
   .op_state, .hold_active);

// ===== tb_drive_power_state_machine.sv
// Self-checking bench for the drive power state machine
`timescale 1ns/1ps
module tb_drive_power_state_machine;
   logic                sys_clk = 1'b0;
   logic                rstn = 1'b0;
   logic                init_done = 1'b0;
   logic                dc_bus_ok = 1'b1;
   logic                fault_event = 1'b0;
   logic                fault_react_done = 1'b0;
   logic                decel_done = 1'b0;
   logic                cmd_wr, pwr, mot, dec, hld;
   logic [15:0]         cmd_wr_data, cw, sw_out;
   logic [15:0]         mcw = 16'h0000;
   logic [3:0]          mode;
   dps_pkg::dps_state_t st;
   int                  miscompares = 0;
   int                  compares = 0;
   int                  ms;
   always #10 sys_clk = ~sys_clk;
   dps_power_state_machine u_dut (.sys_clk, .rstn, .cmd_wr, .cmd_wr_data, .init_done,
      .dc_bus_ok, .fault_event, .fault_react_done, .decel_done, .drive_command_word(cw),
      .drive_state_word(sw_out), .op_state(st), .power_stage_on(pwr), .motion_enable(mot),
      .decel_active(dec), .hold_active(hld), .mode_ctrl(mode));
   dps_master_model u_mst (.sys_clk, .cmd_wr, .cmd_wr_data);
   function automatic int step(int s, logic [15:0] d, logic [15:0] p, logic bus);
      step = s;
      case (s)
         dps_pkg::ST_INHIBITED: if (d[2:0] == 3'h6 && bus) step = dps_pkg::ST_ARMED;
         dps_pkg::ST_ARMED: if (!d[1] || !d[2]) step = dps_pkg::ST_INHIBITED;
            else if (d[2:0] == 3'h7) step = dps_pkg::ST_ENERGIZED;
         dps_pkg::ST_ENERGIZED: if (!d[1] || !d[2]) step = dps_pkg::ST_INHIBITED;
            else if (d[2:0] == 3'h6) step = dps_pkg::ST_ARMED;
            else if (d[3:0] == 4'hf) step = dps_pkg::ST_RUNNING;
         dps_pkg::ST_RUNNING: if (!d[1]) step = dps_pkg::ST_INHIBITED;
            else if (!d[2]) step = dps_pkg::ST_EMER_DECEL;
            else if (d[2:0] == 3'h6) step = dps_pkg::ST_ARMED;
            else if (d[3:0] == 4'h7) step = dps_pkg::ST_ENERGIZED;
         dps_pkg::ST_EMER_DECEL: if (!d[1]) step = dps_pkg::ST_INHIBITED;
            else if (d[3:0] == 4'hf) step = dps_pkg::ST_RUNNING;
         dps_pkg::ST_ERR_LATCHED: if (d[7] && !p[7]) step = dps_pkg::ST_INHIBITED;
         default: ;
      endcase
   endfunction : step
   function automatic logic [15:0] ew(int s);
      case (s)
         dps_pkg::ST_INHIBITED: ew = 16'h0040;
         dps_pkg::ST_ARMED: ew = 16'h0021;
         dps_pkg::ST_ENERGIZED: ew = 16'h0023;
         dps_pkg::ST_RUNNING: ew = 16'h0027;
         dps_pkg::ST_EMER_DECEL: ew = 16'h0007;
         dps_pkg::ST_ERR_REACT: ew = 16'h000f;
         dps_pkg::ST_ERR_LATCHED: ew = 16'h0008;
         default: ew = 16'h0000;
      endcase
   endfunction : ew
   task automatic chk();
      logic [15:0] e;
      logic [42:0] x;
      logic [42:0] y;
      @(negedge sys_clk);
      e = ew(ms) | {7'h00, mcw[8], 3'h0, dc_bus_ok, 4'h0};
      x = {ms[2:0], e, mcw, e[1], e[2] & e[5], e[2] & !e[5], mcw[8], mcw[9], mcw[6:4]};
      y = {st, sw_out, cw, pwr, mot, dec, hld, mode};
      compares++;
      if (y !== x) begin
         miscompares++;
         $display("ERROR outputs expected %h seen %h", x, y);
      end
      @(posedge sys_clk);
   endtask : chk
   task automatic wr(input logic [15:0] d);
      u_mst.put(d, $urandom_range(2));
      ms = step(ms, d, mcw, dc_bus_ok);
      mcw = d;
      chk();
   endtask : wr
   task automatic ev(input int k, input int nxt);
      case (k)
         0: fault_event <= 1'b1;
         1: fault_react_done <= 1'b1;
         2: decel_done <= 1'b1;
         default: init_done <= 1'b1;
      endcase
      @(posedge sys_clk);
      fault_event <= 1'b0;
      fault_react_done <= 1'b0;
      decel_done <= 1'b0;
      ms = nxt;
      chk();
   endtask : ev
   task automatic final_report();
      if (miscompares == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   initial begin
      #1000000;
      miscompares++;
      final_report();
   end
   initial begin
      static logic [99:0] seq = 100'h67fbf767f6067267fd67367fb;
      void'($urandom(27));
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      ms = dps_pkg::ST_INIT_PENDING;
      chk();
      wr(16'h0007);
      ev(3, dps_pkg::ST_INHIBITED);
      dc_bus_ok <= 1'b0;
      wr(16'h0006);
      dc_bus_ok <= 1'b1;
      for (int i = 24; i >= 0; i--) begin
         wr({12'h000, seq[i*4 +: 4]} | (16'($urandom) & 16'hff70));
      end
      ev(2, dps_pkg::ST_INHIBITED);
      for (int i = 0; i < 60; i++) begin
         dc_bus_ok <= 1'($urandom);
         wr(16'($urandom));
      end
      dc_bus_ok <= 1'b1;
      ev(0, dps_pkg::ST_ERR_REACT);
      wr(16'h0006);
      ev(1, dps_pkg::ST_ERR_LATCHED);
      wr(16'h0000);
      wr(16'h0080);
      ev(0, dps_pkg::ST_ERR_REACT);
      ev(1, dps_pkg::ST_ERR_LATCHED);
      wr(16'h0080);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      ms = dps_pkg::ST_INHIBITED;
      mcw = 16'h0000;
      @(posedge sys_clk);
      chk();
      final_report();
   end
endmodule : tb_drive_power_state_machine
